// file: rtl/aat_regs.sv
// Register bank: table base, two arbitration slice timers, usable memory limit.
// Assumes a configuration master on the aat_cfg_if link and one CLOCK.
//
// Notes on behaviour
// R1 - Table base bits 31:12 writable, 11:0 reserved
// R2 - Translation uses base pointer to locate entries
// R3 - Software changes base only with buffer disabled
// R4 - Base register accepts updates at run time
// R5 - Slice bits 7:3, units of eight clocks
// R6 - Slice value zero disables time slicing
// R7 - Timer byte read as clock count directly
// R8 - Slice also governs processor-initiated transactions
// R9 - Low-priority bits 7:3 set minimum tenure
// R10 - Low slice spans several same-type transactions
// R11 - After expiry, hand off only if pending
// R12 - High-priority request bypasses low-priority timer
// R13 - Low-priority value zero disables tenure
// R14 - Limit bits 15:3 hold address 31:19
// R15 - Limit address bits 18:0 compare as zero
// R16 - Software programs smaller usable limit value
// R17 - Software programs limit at least 0400h
// R18 - Software never programs limit above FEC0_0000h
// R19 - Timers reload on grant, count, signal expiry
`include "aat_consts.svh"
`default_nettype none
module aat_regs
    import aat_pkg::*;
(
    // Clock and reset
    input  wire logic        CLOCK,
    input  wire logic        RST,
    // Configuration link
    aat_cfg_if.dev           CFG,
    // Aperture translation
    input  wire logic [19:0] XL_INDEX,
    output logic      [31:0] XL_ENTRY_ADDR,
    // Memory limit compare
    input  wire logic [31:0] MEM_ADDR,
    output logic             MEM_BELOW_LIMIT,
    // Arbitration requests and grant
    input  wire logic        REQ_MASTER,
    input  wire logic        REQ_CPU,
    input  wire logic        REQ_LOW,
    input  wire logic        REQ_HIGH,
    input  wire logic        XFER_DONE,
    output logic             GNT_MASTER,
    output logic             GNT_CPU,
    output logic             GNT_LOW,
    output logic             GNT_HIGH,
    output logic             SLICE_EXPIRED,
    output logic             LOW_EXPIRED
);
    logic [31:0] ttb_reg;
    logic [7:0]  slice_reg;
    logic [7:0]  lpslice_reg;
    logic [15:0] uml_reg;
    logic [31:0] rdata_reg;
    logic [1:0]  div_reg;
    logic        tick;
    logic [7:0]  slice_cnt_reg;
    logic [7:0]  low_cnt_reg;
    logic        slice_exp_reg;
    logic        low_exp_reg;
    aat_owner_t  owner_reg;
    aat_owner_t  owner_next;
    logic        cpu_turn_reg;
    logic        cpu_turn_next;
    logic        new_grant;

    function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                          input logic [31:0] mask);
        merge = (new_v & mask) | (old_v & ~mask);
    endfunction

    // Registers; reserved bits stay zero
    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            ttb_reg     <= `AAT_RST_TTB;
            slice_reg   <= `AAT_RST_SLICE;
            lpslice_reg <= `AAT_RST_LPSLICE;
            uml_reg     <= `AAT_RST_UML;
        end
        else if (CFG.wr)
        begin
            unique case (CFG.addr)
                `AAT_OFF_TTB:     ttb_reg     <= merge(ttb_reg, CFG.wdata, `AAT_TTB_MASK); // R1 R4
                `AAT_OFF_SLICE:   slice_reg   <= CFG.wdata[7:0] & `AAT_SLICE_MASK; // R5 R7
                `AAT_OFF_LPSLICE: lpslice_reg <= CFG.wdata[7:0] & `AAT_SLICE_MASK; // R9
                `AAT_OFF_UML:     uml_reg     <= CFG.wdata[15:0] & `AAT_UML_MASK; // R14
                default:          ;
            endcase
        end
    end

    // Read data one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
            rdata_reg <= 32'h00000000;
        else if (CFG.rd)
        begin
            unique case (CFG.addr)
                `AAT_OFF_TTB:     rdata_reg <= ttb_reg;
                `AAT_OFF_SLICE:   rdata_reg <= {24'h000000, slice_reg};
                `AAT_OFF_LPSLICE: rdata_reg <= {24'h000000, lpslice_reg};
                `AAT_OFF_UML:     rdata_reg <= {16'h0000, uml_reg};
                default:          rdata_reg <= 32'h00000000;
            endcase
        end
        else
            rdata_reg <= 32'h00000000;
    end
    assign CFG.rdata = rdata_reg;

    // Each entry is one word; base pointer supplies the page
    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
            XL_ENTRY_ADDR <= 32'h00000000;
        else
            XL_ENTRY_ADDR <= ttb_reg + {10'h000, XL_INDEX, 2'h0}; // R2
    end

    // Limit is 512 KB aligned: low address bits ignored
    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
            MEM_BELOW_LIMIT <= 1'b0;
        else
            MEM_BELOW_LIMIT <= MEM_ADDR[31:19] < uml_reg[15:3]; // R14 R15
    end

    // Slower 66 MHz-class tick as an enable pulse
    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
            div_reg <= 2'h0;
        else
            div_reg <= (div_reg == `AAT_TICK_DIV) ? 2'h0 : div_reg + 2'h1;
    end
    assign tick = (div_reg == `AAT_TICK_DIV);

    // Arbiter: high priority preempts, slices gate hand-over
    always_comb
    begin
        owner_next    = owner_reg;
        cpu_turn_next = cpu_turn_reg;
        if (REQ_HIGH && owner_reg != AAT_OWN_HIGH)
            owner_next = AAT_OWN_HIGH; // R12
        else
        begin
            unique case (owner_reg)
                AAT_OWN_NONE:
                    if (REQ_LOW)
                        owner_next = AAT_OWN_LOW;
                    else if (REQ_MASTER && REQ_CPU && (slice_exp_reg || slice_reg == 8'h00))
                        cpu_turn_next = ~cpu_turn_reg; // R5 R6 R8
                    else if (REQ_CPU && !REQ_MASTER)
                        cpu_turn_next = 1'b1;
                    else if (REQ_MASTER && !REQ_CPU)
                        cpu_turn_next = 1'b0;
                AAT_OWN_LOW:
                    if (!REQ_LOW || ((low_exp_reg || lpslice_reg == 8'h00) &&
                                     (REQ_MASTER || REQ_CPU))) // R10 R11 R13
                        owner_next = AAT_OWN_NONE;
                AAT_OWN_HIGH:
                    if (XFER_DONE && !REQ_HIGH)
                        owner_next = AAT_OWN_NONE;
            endcase
        end
    end

    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            owner_reg    <= AAT_OWN_NONE;
            cpu_turn_reg <= 1'b0;
        end
        else
        begin
            owner_reg    <= owner_next;
            cpu_turn_reg <= cpu_turn_next;
        end
    end

    assign new_grant = (owner_next != owner_reg) || (cpu_turn_next != cpu_turn_reg);

    // Timers reload on each new grant, count down on ticks
    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            slice_cnt_reg <= 8'h00;
            slice_exp_reg <= 1'b0;
        end
        else if (new_grant)
        begin
            slice_cnt_reg <= slice_reg; // R19 R7
            slice_exp_reg <= 1'b0;
        end
        else if (tick && slice_reg != 8'h00 && !slice_exp_reg)
        begin
            slice_cnt_reg <= slice_cnt_reg - 8'h01;
            slice_exp_reg <= (slice_cnt_reg <= 8'h01); // R19
        end
    end

    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            low_cnt_reg <= 8'h00;
            low_exp_reg <= 1'b0;
        end
        else if (owner_next == AAT_OWN_LOW && owner_reg != AAT_OWN_LOW)
        begin
            low_cnt_reg <= lpslice_reg; // R19 R9
            low_exp_reg <= 1'b0;
        end
        else if (tick && owner_reg == AAT_OWN_LOW && lpslice_reg != 8'h00 && !low_exp_reg)
        begin
            low_cnt_reg <= low_cnt_reg - 8'h01; // R10
            low_exp_reg <= (low_cnt_reg <= 8'h01);
        end
    end

    assign GNT_HIGH      = owner_reg == AAT_OWN_HIGH;
    assign GNT_LOW       = owner_reg == AAT_OWN_LOW;
    assign GNT_CPU       = owner_reg == AAT_OWN_NONE && REQ_CPU && cpu_turn_reg;
    assign GNT_MASTER    = owner_reg == AAT_OWN_NONE && REQ_MASTER && !cpu_turn_reg;
    assign SLICE_EXPIRED = slice_exp_reg;
    assign LOW_EXPIRED   = low_exp_reg;
endmodule : aat_regs
`default_nettype wire

// file: rtl/aat_consts.svh
// Constants for the aperture / arbitration-timer register bank.
// Assumes inclusion by bare name from rtl/ files.
`ifndef AAT_CONSTS_SVH
`define AAT_CONSTS_SVH
`define AAT_OFF_TTB        8'hB8
`define AAT_OFF_SLICE      8'hBC
`define AAT_OFF_LPSLICE    8'hBD
`define AAT_OFF_UML        8'hC4
`define AAT_RST_TTB        32'h00000000
`define AAT_RST_SLICE      8'h10
`define AAT_RST_LPSLICE    8'h10
`define AAT_RST_UML        16'h0400
`define AAT_TTB_MASK       32'hFFFFF000
`define AAT_SLICE_MASK     8'hF8
`define AAT_UML_MASK       16'hFFF8
// 66 MHz tick from 250 MHz: divide by 4 (about 62.5 MHz, nearest whole ratio)
`define AAT_TICK_DIV       2'h3
// Host command port offsets (designer's own)
`define AAT_CMD_ADDR       4'h0
`define AAT_CMD_WDATA      4'h1
`define AAT_CMD_GO         4'h2
`define AAT_CMD_RDATA      4'h3
`define AAT_CMD_STATUS     4'h4
`endif

// file: rtl/aat_pkg.sv
// Types shared by both ends of the register bank link.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package aat_pkg;
    typedef enum logic [2:0]
    {
        AAT_IDLE = 3'b001,
        AAT_REQ  = 3'b010,
        AAT_WAIT = 3'b100
    } aat_host_state_t;
    typedef enum logic [2:0]
    {
        AAT_OWN_NONE = 3'b001,
        AAT_OWN_LOW  = 3'b010,
        AAT_OWN_HIGH = 3'b100
    } aat_owner_t;
endpackage : aat_pkg
`default_nettype wire

// file: rtl/aat_cfg_if.sv
// Configuration link between the host controller and the register bank.
// Assumes both ends share CLOCK; read data follow a read by one cycle.
`default_nettype none
interface aat_cfg_if;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
    logic [31:0] rdata;
    modport dev  (input addr, input wdata, input wr, input rd, output rdata);
    modport host (output addr, output wdata, output wr, output rd, input rdata);
endinterface : aat_cfg_if
`default_nettype wire

// file: rtl/aat_host.sv
// Host controller: takes software orders and drives the configuration link.
// Assumes the register bank answers reads one cycle after the strobe.
`include "aat_consts.svh"
`default_nettype none
module aat_host
    import aat_pkg::*;
(
    // Clock and reset
    input  wire logic        CLOCK,
    input  wire logic        RST,
    // Software port
    input  wire logic [3:0]  SW_ADDR,
    input  wire logic [31:0] SW_WDATA,
    input  wire logic        SW_WR,
    input  wire logic        SW_RD,
    output logic      [31:0] SW_RDATA,
    // Configuration link
    aat_cfg_if.host          CFG
);
    aat_host_state_t state_reg;
    logic [7:0]      addr_reg;
    logic [31:0]     wdata_reg;
    logic [31:0]     result_reg;
    logic            is_wr_reg;
    logic            go;

    // GO word: bit0 write, bit1 read; ignored while busy
    assign go = SW_WR && SW_ADDR == `AAT_CMD_GO && state_reg == AAT_IDLE && (SW_WDATA[0] ^ SW_WDATA[1]);

    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            addr_reg  <= 8'h00;
            wdata_reg <= 32'h00000000;
            is_wr_reg <= 1'b0;
        end
        else if (SW_WR)
        begin
            if (SW_ADDR == `AAT_CMD_ADDR)
                addr_reg <= SW_WDATA[7:0];
            if (SW_ADDR == `AAT_CMD_WDATA)
                wdata_reg <= SW_WDATA; // R3 R16 R17 R18
            if (go)
                is_wr_reg <= SW_WDATA[0];
        end
    end

    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
            state_reg <= AAT_IDLE;
        else
        begin
            unique case (state_reg)
                AAT_IDLE: if (go) state_reg <= AAT_REQ;
                AAT_REQ:  state_reg <= is_wr_reg ? AAT_IDLE : AAT_WAIT;
                AAT_WAIT: state_reg <= AAT_IDLE;
            endcase
        end
    end

    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
            result_reg <= 32'h00000000;
        else if (state_reg == AAT_WAIT)
            result_reg <= CFG.rdata;
    end

    assign CFG.addr  = addr_reg;
    assign CFG.wdata = wdata_reg;
    assign CFG.wr    = state_reg == AAT_REQ && is_wr_reg;
    assign CFG.rd    = state_reg == AAT_REQ && !is_wr_reg;

    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
            SW_RDATA <= 32'h00000000;
        else if (SW_RD)
        begin
            unique case (SW_ADDR)
                `AAT_CMD_ADDR:   SW_RDATA <= {24'h000000, addr_reg};
                `AAT_CMD_WDATA:  SW_RDATA <= wdata_reg;
                `AAT_CMD_RDATA:  SW_RDATA <= result_reg;
                `AAT_CMD_STATUS: SW_RDATA <= {31'h00000000, state_reg != AAT_IDLE};
                default:         SW_RDATA <= 32'h00000000;
            endcase
        end
        else
            SW_RDATA <= 32'h00000000;
    end
endmodule : aat_host
`default_nettype wire

// file: tb/aat_regs_asserts.sv
// Checker for the configuration link between host controller and register bank.
// Assumes it is instantiated beside the link interface and sees CLOCK and RST.
`include "aat_consts.svh"
`default_nettype none
module aat_regs_asserts
(
    // Clock and reset
    input wire logic        CLOCK,
    input wire logic        RST,
    // Configuration link
    input wire logic [7:0]  addr,
    input wire logic [31:0] wdata,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [31:0] rdata
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [31:0] ttb_reg;
    logic [7:0]  slice_reg;
    logic [7:0]  lp_reg;
    logic [15:0] uml_reg;
    // Shadows store what the bank must keep, reserved bits already cleared
    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            ttb_reg   <= `AAT_RST_TTB;
            slice_reg <= `AAT_RST_SLICE;
            lp_reg    <= `AAT_RST_LPSLICE;
            uml_reg   <= `AAT_RST_UML;
        end
        else if (wr)
        begin
            if (addr == `AAT_OFF_TTB) ttb_reg <= wdata & `AAT_TTB_MASK;
            if (addr == `AAT_OFF_SLICE) slice_reg <= wdata[7:0] & `AAT_SLICE_MASK;
            if (addr == `AAT_OFF_LPSLICE) lp_reg <= wdata[7:0] & `AAT_SLICE_MASK;
            if (addr == `AAT_OFF_UML) uml_reg <= wdata[15:0] & `AAT_UML_MASK;
        end
    end
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RST);
    sequence s_read(logic [7:0] off);
        rd && addr == off;
    endsequence
    property p_readback(logic [7:0] off, logic [31:0] val);
        s_read(off) |=> rdata == val;
    endproperty
    a_ttb_readback: assert property (p_readback(`AAT_OFF_TTB, ttb_reg))
        else $error("table base read back wrong");
    a_slice_readback: assert property (p_readback(`AAT_OFF_SLICE, {24'h000000, slice_reg}))
        else $error("slice read back wrong");
    a_lp_readback: assert property (p_readback(`AAT_OFF_LPSLICE, {24'h000000, lp_reg}))
        else $error("low slice read back wrong");
    a_limit_readback: assert property (p_readback(`AAT_OFF_UML, {16'h0000, uml_reg}))
        else $error("limit read back wrong");
    a_rdata_idle: assert property (!rd |=> rdata == 32'h00000000)
        else $error("read data outside answer cycle");
    a_strobe_excl: assert property (!(wr && rd))
        else $error("write and read strobes together");
    a_wr_pulse: assert property ($rose(wr) |=> !wr)
        else $error("write strobe longer than one cycle");
    a_rd_pulse: assert property (rd |=> !rd ##1 !rd)
        else $error("read strobes too close");
endmodule // aat_regs_asserts
`default_nettype wire

// file: tb/aat_regs_bench.sv
// Bench: software port orders, register model, arbitration and compare checks.
// Assumes the host controller and register bank joined by one aat_cfg_if.
`include "aat_consts.svh"
`default_nettype none
module aat_regs_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import aat_pkg::*;
    logic        clock = 0, rst = 1, sw_wr = 0, sw_rd = 0;
    logic [3:0]  sw_addr = 4'h0, req = 4'h0;
    logic [31:0] sw_wdata = 0, sw_rdata, xl_entry, mem_addr = 0, seed = 32'h77A8, q;
    logic [19:0] xl_index = 20'h00000;
    logic        xfer_done = 0, below, slice_exp, low_exp;
    logic [3:0]  gnts;
    logic [7:0]  offs[5] = '{8'hB8, 8'hBC, 8'hBD, 8'hC4, 8'hC0};
    logic [31:0] msks[5] = '{32'hFFFFF000, 32'h000000F8, 32'h000000F8, 32'h0000FFF8, 32'h00000000};
    logic [31:0] mdl[5] = '{32'h00000000, 32'h00000010, 32'h00000010, 32'h00000400, 32'h00000000};
    int          mismatches = 0, checks = 0, n, i;
    aat_cfg_if i_aat_cfg_if ();
    aat_host i_aat_host (.CLOCK(clock), .RST(rst), .SW_ADDR(sw_addr), .SW_WDATA(sw_wdata), .SW_WR(sw_wr),
        .SW_RD(sw_rd), .SW_RDATA(sw_rdata), .CFG(i_aat_cfg_if.host));
    aat_regs i_aat_regs (.CLOCK(clock), .RST(rst), .CFG(i_aat_cfg_if.dev), .XL_INDEX(xl_index),
        .XL_ENTRY_ADDR(xl_entry), .MEM_ADDR(mem_addr), .MEM_BELOW_LIMIT(below), .REQ_MASTER(req[0]),
        .REQ_CPU(req[1]), .REQ_LOW(req[2]), .REQ_HIGH(req[3]), .XFER_DONE(xfer_done),
        .GNT_MASTER(gnts[0]), .GNT_CPU(gnts[1]), .GNT_LOW(gnts[2]), .GNT_HIGH(gnts[3]),
        .SLICE_EXPIRED(slice_exp), .LOW_EXPIRED(low_exp));
    aat_regs_asserts i_aat_regs_asserts (.CLOCK(clock), .RST(rst), .addr(i_aat_cfg_if.addr),
        .wdata(i_aat_cfg_if.wdata), .wr(i_aat_cfg_if.wr), .rd(i_aat_cfg_if.rd), .rdata(i_aat_cfg_if.rdata));
    initial forever #2 clock = ~clock;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("BAD t=%0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    task automatic sw_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock);
        sw_addr  <= a;
        sw_wdata <= d;
        sw_wr    <= 1'b1;
        @(posedge clock);
        sw_wr    <= 1'b0;
    endtask
    task automatic sw_read(input logic [3:0] a, output logic [31:0] d);
        @(posedge clock);
        sw_addr <= a;
        sw_rd   <= 1'b1;
        @(posedge clock);
        sw_rd   <= 1'b0;
        #1 d = sw_rdata;
        // Hand back on an edge so callers drive on it
        @(posedge clock);
    endtask
    task automatic wait_idle();
        logic [31:0] s;
        for (int k = 0; k < 20; k++)
        begin
            sw_read(`AAT_CMD_STATUS, s);
            if (s[0] === 1'b0) return;
        end
        chk(1, 0, "host stays busy");
        conclude();
    endtask
    task automatic cfg_write(input logic [7:0] off, input logic [31:0] d);
        sw_write(`AAT_CMD_ADDR, {24'h000000, off});
        sw_write(`AAT_CMD_WDATA, d);
        sw_write(`AAT_CMD_GO, 32'h00000001);
        wait_idle();
    endtask
    task automatic cfg_read(input logic [7:0] off, output logic [31:0] d);
        sw_write(`AAT_CMD_ADDR, {24'h000000, off});
        sw_write(`AAT_CMD_GO, 32'h00000002);
        wait_idle();
        sw_read(`AAT_CMD_RDATA, d);
    endtask
    task automatic wait_gnt(input int sel, input int lim);
        for (int k = 0; k < lim; k++)
        begin
            if (gnts[sel] === 1'b1) return;
            @(posedge clock);
            #1;
        end
        chk(1, 0, "grant never came");
        conclude();
    endtask
    // Length of a tenure in clocks, after waiting up to 200 clocks for its grant
    task automatic hold(input int sel, output int len);
        wait_gnt(sel, 200);
        for (len = 0; len < 2000 && gnts[sel] === 1'b1; len++) @(posedge clock) #1;
    endtask
    initial
    begin
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        for (i = 0; i < 5; i++) begin cfg_read(offs[i], q); chk(q, mdl[i], "reset value"); end
        mem_addr <= 32'h03FFFFFF;
        repeat (3) @(posedge clock) #1;
        chk(below, 1, "limit just below");
        @(posedge clock);
        mem_addr <= 32'h0407FFFF;
        repeat (3) @(posedge clock) #1;
        chk(below, 0, "limit low bits as zero");
        $display("test reset and limit done");
        for (i = 0; i < 15; i++)
        begin
            seed = lfsr(seed);
            // Limit stays inside the range software may program
            q = (i % 5 == 3) ? 32'h00000400 + seed % 32'h0000FAC1 : seed;
            cfg_write(offs[i % 5], q);
            mdl[i % 5] = q & msks[i % 5];
            cfg_read(offs[i % 5], q);
            chk(q, mdl[i % 5], "register read back");
            xl_index <= seed[31:12];
            repeat (3) @(posedge clock) #1;
            chk(xl_entry, mdl[0] + {10'h000, seed[31:12], 2'h0}, "table entry address");
        end
        $display("test registers done");
        cfg_write(8'hBC, 32'h00000018);
        req <= 4'h3;
        hold(0, n);
        chk(n >= 92 && n <= 108, 1, "master slice length");
        wait_gnt(1, 4);
        chk(slice_exp, 0, "slice timer restarted on grant");
        hold(1, n);
        chk(n >= 92 && n <= 108, 1, "cpu slice length");
        cfg_write(8'hBC, 32'h00000000);
        hold(0, n);
        chk(n <= 8, 1, "slice zero alternates");
        @(posedge clock);
        req <= 4'h0;
        cfg_write(8'hBD, 32'h00000008);
        req <= 4'h4;
        wait_gnt(2, 20);
        repeat (60) @(posedge clock) #1;
        chk(gnts[2], 1, "low kept without other request");
        chk(low_exp, 1, "low timer expired while kept");
        @(posedge clock);
        req <= 4'h0;
        repeat (4) @(posedge clock);
        req <= 4'h4;
        wait_gnt(2, 20);
        @(posedge clock);
        req <= 4'h5;
        hold(2, n);
        chk(n >= 28 && n <= 44, 1, "low minimum tenure");
        @(posedge clock);
        req <= 4'h0;
        repeat (4) @(posedge clock);
        req <= 4'h4;
        wait_gnt(2, 20);
        @(posedge clock);
        req <= 4'hC;
        wait_gnt(3, 3);
        chk(gnts[2], 0, "high takes over from low");
        @(posedge clock);
        req <= 4'h0;
        xfer_done <= 1'b1;
        @(posedge clock);
        xfer_done <= 1'b0;
        repeat (3) @(posedge clock) #1;
        chk(gnts[3], 0, "high released");
        cfg_write(8'hBD, 32'h00000000);
        req <= 4'h4;
        wait_gnt(2, 20);
        @(posedge clock);
        req <= 4'h5;
        hold(2, n);
        chk(n <= 8, 1, "low slice zero");
        $display("test arbitration done");
        conclude();
    end
endmodule // aat_regs_bench
`default_nettype wire
